/* design/seq_pkg.sv */
// Shared constants for the counter and converter sequencer and its host.
// Assumes both ends run on one 25 MHz clock, pclk.
package seq_pkg;
  // System clock rate in hertz.
  localparam int CLK_HZ = 25_000_000;
  // Reference input rate in hertz.
  localparam int REF_HZ = 1_000_000;
  // Timebase rate in hertz.
  localparam int TB_HZ = 1;
  // Reference ticks in one half-cycle of the timebase.
  localparam int TB_HALF_REFS = REF_HZ / (2 * TB_HZ);
  // Frequency multiplication applied to the limited IF input.
  localparam logic [15:0] IF_MULT = 16'h0014;
  // Number of BCD digits in the shared counter.
  localparam int DIGITS = 6;
  // Counter value after reset and after each readout (990,000).
  localparam logic [23:0] CNT_PRESET = 24'h990000;
  // Step tracking latch patterns.
  localparam logic [2:0] STEP_IDLE = 3'h7;
  localparam logic [2:0] STEP_RAMP_UP = 3'h3;
  localparam logic [2:0] STEP_COUNT_UP = 3'h1;
  localparam logic [2:0] STEP_DISCHARGE = 3'h0;
  // Host register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FREQ = 8'h08;
  localparam logic [7:0] OFS_LEVEL = 8'h0c;
  // Control field positions.
  localparam int CTRL_RUN = 0;
  localparam int CTRL_DISPLAY = 1;
  // Device sequencer states.
  typedef enum logic [2:0] {
    S_IDLE, S_ARMED, S_FREQ, S_RAMP_UP, S_COUNT_UP, S_DISCHARGE
  } dev_state_t;
  // Host controller states.
  typedef enum logic [3:0] {
    H_IDLE, H_F_WAIT_LOW, H_F_KICK, H_F_WAIT_FALL, H_F_WAIT_RISE,
    H_C_KICK, H_C_WAIT_FALL, H_C_WAIT_RISE, H_SCAN, H_GAP, H_TAKE
  } host_state_t;
endpackage

/* design/seq_link_if.sv */
// Link between the sequencer device and its host controller.
// Assumes both ends are clocked by the same pclk.
`timescale 1ns/10ps
interface seq_link_if;
  logic count_mode_select; // High selects frequency counting.
  logic kickoff_n; // Active-low start pulse.
  logic done; // High when the counter is stopped.
  logic scan_strobe; // One pulse presents the next digit.
  logic bcd_weight_one; // Digit bit of weight one.
  logic bcd_weight_two; // Digit bit of weight two.
  logic bcd_weight_four; // Digit bit of weight four.
  logic bcd_weight_eight; // Digit bit of weight eight.
  logic timebase_1hz; // One hertz square wave.
  // Device end.
  modport dev (
    input count_mode_select, kickoff_n, scan_strobe,
    output done, bcd_weight_one, bcd_weight_two, bcd_weight_four,
    output bcd_weight_eight, timebase_1hz
  );
  // Host end.
  modport host (
    output count_mode_select, kickoff_n, scan_strobe,
    input done, bcd_weight_one, bcd_weight_two, bcd_weight_four,
    input bcd_weight_eight, timebase_1hz
  );
endinterface // seq_link_if

/* design/sequence_controller.sv */
// Device end: dividers, IF multiplier, shared counter and sequencer.
// Assumes ref_1mhz, if_in and comparator are asynchronous pins and the
// link signals come from logic on pclk.
// How it works
// RULE1: Divide reference to 1 Hz and 500 kHz.
// RULE2: Multiply the IF frequency by twenty.
// RULE3: Clear counter, gate multiplied IF half-second.
// RULE4: Each scan pulse presents the next digit.
// RULE5: Display on: count, convert, then wait.
// RULE6: Display off: counter used only for conversions.
// RULE7: Host raises mode select in negative half.
// RULE8: Kickoff arms start at next timebase fall.
// RULE9: Frequency start clears the counter.
// RULE10: Frequency start clears every divider stage.
// RULE11: Timebase rising stops the frequency count.
// RULE12: Done low while frequency counting.
// RULE13: Host drops mode select, then reads.
// RULE14: Count equals ten times IF hertz.
// RULE15: Readout presets 990000 and sequencer idles.
// RULE16: Mode low counts the 500 kHz clock.
// RULE17: Idle latches all high; four steps.
// RULE18: Kickoff starts conversion, integrator ramps up.
// RULE19: Comparator rise starts counting, done low.
// RULE20: Carry reverses the integrator to discharge.
// RULE21: Comparator fall stops counting, done high.
// RULE22: Synchronise comparator and timebase edges.
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/10ps
module sequence_controller
  import seq_pkg::*;
#(
  parameter int TB_HALF = TB_HALF_REFS
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Analogue side pins.
  input wire logic ref_1mhz,
  input wire logic if_in,
  input wire logic comparator,
  output logic integ_dir_r,
  output logic [2:0] step_tracking_latches,
  // Link to the host.
  seq_link_if.dev link
);

  // Increments a six-digit BCD value; bit 24 is the wrap carry.
  function automatic logic [24:0] bcd_inc(input logic [23:0] v);
    logic [23:0] r;
    logic c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < DIGITS; i++) begin
      if (c) begin
        if (r[i*4 +: 4] == 4'h9) begin
          r[i*4 +: 4] = 4'h0;
        end else begin
          r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
          c = 1'b0;
        end
      end
    end
    return {c, r};
  endfunction

  logic [1:0] ref_s; // Reference synchroniser.
  logic [1:0] if_s; // IF synchroniser.
  logic [1:0] cmp_s; // Comparator synchroniser.
  logic ref_d; // Previous synchronised reference.
  logic if_d; // Previous synchronised IF.
  logic cmp_d; // Previous synchronised comparator.
  logic sq500_r; // 500 kHz square wave.
  logic tb_r; // 1 Hz square wave.
  logic tb_d; // Previous timebase level.
  logic [19:0] tb_cnt_r; // Reference ticks in this half-cycle.
  logic [15:0] per_cnt_r; // Clocks since the last IF rise.
  logic [15:0] period_r; // Last measured IF period.
  logic [15:0] acc_r; // Phase accumulator of the multiplier.
  logic mult_pulse_r; // One pulse per twentieth of an IF period.
  logic [23:0] cnt_r; // Shared decimal counter, BCD.
  logic carry_r; // Counter wrapped on the last increment.
  logic kick_d; // Previous kickoff level.
  logic scan_d; // Previous scan strobe level.
  logic [2:0] dig_r; // Digit presented on the next scan.
  logic [3:0] bcd_r; // Digit on the output lines.
  logic done_r; // Done flag.
  dev_state_t state_r; // Sequencer state.
  logic ref_tick; // Reference rising edge.
  logic tick500; // 500 kHz rising edge.
  logic tb_rise; // Timebase rising edge.
  logic tb_fall; // Timebase falling edge.
  logic kick_fall; // Kickoff went low.
  logic scan_rise; // Scan strobe went high.
  logic freq_start; // Frequency gate opens now.
  logic count_en; // Counter advances this cycle.
  logic [24:0] inc; // Incremented counter with carry.

  assign ref_tick = ref_s[1] & ~ref_d;
  assign tick500 = ref_tick & ~sq500_r;
  assign tb_rise = tb_r & ~tb_d;
  assign tb_fall = ~tb_r & tb_d;
  assign kick_fall = ~link.kickoff_n & kick_d;
  assign scan_rise = link.scan_strobe & ~scan_d;
  assign freq_start = (state_r == S_ARMED) && tb_fall; // RULE8
  assign inc = bcd_inc(cnt_r);

  // Two-stage synchronisers for all asynchronous pins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_s <= 2'h0;
      if_s <= 2'h0;
      cmp_s <= 2'h0;
      ref_d <= 1'b0;
      if_d <= 1'b0;
      cmp_d <= 1'b0;
      tb_d <= 1'b1;
      kick_d <= 1'b1;
      scan_d <= 1'b0;
    end else begin
      ref_s <= {ref_s[0], ref_1mhz}; // RULE22
      if_s <= {if_s[0], if_in};
      cmp_s <= {cmp_s[0], comparator}; // RULE22
      ref_d <= ref_s[1];
      if_d <= if_s[1];
      cmp_d <= cmp_s[1];
      tb_d <= tb_r; // RULE22
      kick_d <= link.kickoff_n;
      scan_d <= link.scan_strobe;
    end
  end

  // Divider chain; cleared whole when a frequency gate opens.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sq500_r <= 1'b0;
      tb_r <= 1'b1;
      tb_cnt_r <= 20'h00000;
    end else if (freq_start) begin
      sq500_r <= 1'b0; // RULE10
      tb_r <= 1'b0; // RULE10
      tb_cnt_r <= 20'h00000; // RULE10
    end else if (ref_tick) begin
      sq500_r <= ~sq500_r; // RULE1
      if (tb_cnt_r == 20'(TB_HALF - 1)) begin
        tb_cnt_r <= 20'h00000;
        tb_r <= ~tb_r; // RULE1
      end else begin
        tb_cnt_r <= tb_cnt_r + 20'h00001;
      end
    end
  end

  // IF multiplier: period measurement and a phase accumulator that
  // emits twenty pulses per measured period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_r <= 16'h0000;
      period_r <= 16'hffff;
      acc_r <= 16'h0000;
      mult_pulse_r <= 1'b0;
    end else begin
      if (if_s[1] && !if_d) begin
        period_r <= per_cnt_r + 16'h0001;
        per_cnt_r <= 16'h0000;
      end else if (per_cnt_r != 16'hffff) begin
        per_cnt_r <= per_cnt_r + 16'h0001;
      end
      if (acc_r + IF_MULT >= period_r && period_r > IF_MULT) begin
        acc_r <= acc_r + IF_MULT - period_r; // RULE2
        mult_pulse_r <= 1'b1; // RULE2
      end else begin
        acc_r <= acc_r + IF_MULT;
        mult_pulse_r <= 1'b0;
      end
    end
  end

  // Counter clock source follows the mode select.
  always_comb begin
    if (link.count_mode_select) begin
      count_en = (state_r == S_FREQ) && mult_pulse_r; // RULE3
    end else begin
      count_en = tick500 && (state_r == S_COUNT_UP ||
                             state_r == S_DISCHARGE); // RULE16
    end
  end

  // Shared counter: clear, preset after readout, or advance.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= CNT_PRESET;
      carry_r <= 1'b0;
    end else if (freq_start) begin
      cnt_r <= 24'h000000; // RULE9
      carry_r <= 1'b0;
    end else if (scan_rise && dig_r == 3'(DIGITS - 1)) begin
      cnt_r <= CNT_PRESET; // RULE15
      carry_r <= 1'b0;
    end else if (count_en) begin
      cnt_r <= inc[23:0]; // RULE14
      carry_r <= inc[24]; // RULE20
    end else begin
      carry_r <= 1'b0;
    end
  end

  // Digit readout, least significant digit first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dig_r <= 3'h0;
      bcd_r <= 4'h0;
    end else if (scan_rise) begin
      bcd_r <= cnt_r[dig_r*4 +: 4]; // RULE4
      if (dig_r == 3'(DIGITS - 1)) begin
        dig_r <= 3'h0;
      end else begin
        dig_r <= dig_r + 3'h1; // RULE4
      end
    end
  end

  // Sequencer: frequency gate and the four conversion steps.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      done_r <= 1'b1;
      integ_dir_r <= 1'b1;
    end else begin
      case (state_r)
        S_IDLE: begin
          // Mode high arms a frequency count, low starts a conversion.
          if (kick_fall && link.count_mode_select) begin
            state_r <= S_ARMED; // RULE8 RULE5
          end else if (kick_fall) begin
            state_r <= S_RAMP_UP; // RULE18 RULE6
            integ_dir_r <= 1'b0; // RULE18
          end
        end
        S_ARMED: begin
          // Waits for the timebase to fall.
          if (freq_start) begin
            state_r <= S_FREQ;
            done_r <= 1'b0; // RULE12
          end
        end
        S_FREQ: begin
          // Gate closes when the timebase goes high again.
          if (tb_rise) begin
            state_r <= S_IDLE; // RULE11
            done_r <= 1'b1; // RULE12
          end
        end
        S_RAMP_UP: begin
          if (cmp_s[1] && !cmp_d) begin
            state_r <= S_COUNT_UP; // RULE19
            done_r <= 1'b0; // RULE19
          end
        end
        S_COUNT_UP: begin
          if (carry_r) begin
            state_r <= S_DISCHARGE; // RULE20
            integ_dir_r <= 1'b1; // RULE20
          end
        end
        S_DISCHARGE: begin
          if (!cmp_s[1] && cmp_d) begin
            state_r <= S_IDLE; // RULE21
            done_r <= 1'b1; // RULE21
          end
        end
        default: begin
          state_r <= S_IDLE;
          done_r <= 1'b1;
          integ_dir_r <= 1'b1;
        end
      endcase
    end
  end

  // Step tracking latches mirror the conversion step.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_tracking_latches <= STEP_IDLE;
    end else begin
      case (state_r)
        S_RAMP_UP: step_tracking_latches <= STEP_RAMP_UP; // RULE17
        S_COUNT_UP: step_tracking_latches <= STEP_COUNT_UP; // RULE17
        S_DISCHARGE: step_tracking_latches <= STEP_DISCHARGE; // RULE17
        default: step_tracking_latches <= STEP_IDLE; // RULE17
      endcase
    end
  end

  // Link outputs, all from flip-flops.
  assign link.done = done_r;
  assign link.timebase_1hz = tb_r;
  assign link.bcd_weight_one = bcd_r[0];
  assign link.bcd_weight_two = bcd_r[1];
  assign link.bcd_weight_four = bcd_r[2];
  assign link.bcd_weight_eight = bcd_r[3];

endmodule // sequence_controller

/* design/seq_host.sv */
// Host end: APB registers and the measurement loop that drives the link.
// Assumes the device shares pclk, so link inputs need no synchroniser.
`timescale 1ns/10ps
module seq_host
  import seq_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link to the device.
  seq_link_if.host link
);

  logic [1:0] ctrl_r; // Run and display enables.
  logic [23:0] freq_r; // Last frequency count.
  logic [23:0] level_r; // Last conversion count.
  logic [23:0] shift_r; // Digits being gathered.
  logic [2:0] dig_r; // Digits still to read, minus one.
  logic is_freq_r; // Readout belongs to a frequency count.
  logic mode_r; // Mode select drive.
  logic kick_n_r; // Kickoff drive.
  logic scan_r; // Scan strobe drive.
  host_state_t state_r; // Loop state.
  logic [31:0] rd; // Read mux.
  logic [3:0] digit; // Digit on the link.

  assign digit = {link.bcd_weight_eight, link.bcd_weight_four,
                  link.bcd_weight_two, link.bcd_weight_one};

  // Read decode of the register map.
  always_comb begin
    case (paddr)
      OFS_CTRL: rd = {30'h0, ctrl_r};
      OFS_STATUS: rd = {29'h0, link.timebase_1hz, link.done,
                        state_r != H_IDLE};
      OFS_FREQ: rd = {8'h00, freq_r};
      OFS_LEVEL: rd = {8'h00, level_r};
      default: rd = 32'h00000000;
    endcase
  end

  // APB slave: answers in the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ctrl_r <= 2'h0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h00000000 : rd;
        pslverr <= !(paddr == OFS_CTRL || paddr == OFS_STATUS ||
                     paddr == OFS_FREQ || paddr == OFS_LEVEL);
      end
      if (psel && penable && pready && pwrite && paddr == OFS_CTRL) begin
        ctrl_r <= pwdata[1:0];
      end
    end
  end

  // Measurement loop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= H_IDLE;
      mode_r <= 1'b0;
      kick_n_r <= 1'b1;
      scan_r <= 1'b0;
      is_freq_r <= 1'b0;
      dig_r <= 3'h0;
      shift_r <= 24'h000000;
      freq_r <= 24'h000000;
      level_r <= 24'h000000;
    end else begin
      case (state_r)
        H_IDLE: begin
          // Display on adds a frequency count before each conversion.
          if (ctrl_r[CTRL_RUN] && ctrl_r[CTRL_DISPLAY]) begin
            state_r <= H_F_WAIT_LOW; // RULE5
          end else if (ctrl_r[CTRL_RUN]) begin
            state_r <= H_C_KICK; // RULE6
          end
        end
        H_F_WAIT_LOW: begin
          if (!link.timebase_1hz) begin
            mode_r <= 1'b1; // RULE7
            state_r <= H_F_KICK;
          end
        end
        H_F_KICK: begin
          kick_n_r <= 1'b0; // RULE8
          state_r <= H_F_WAIT_FALL;
        end
        H_F_WAIT_FALL: begin
          kick_n_r <= 1'b1;
          if (!link.done) begin
            state_r <= H_F_WAIT_RISE;
          end
        end
        H_F_WAIT_RISE: begin
          if (link.done) begin
            mode_r <= 1'b0; // RULE13
            is_freq_r <= 1'b1;
            dig_r <= 3'(DIGITS - 1);
            state_r <= H_SCAN; // RULE13
          end
        end
        H_C_KICK: begin
          kick_n_r <= 1'b0; // RULE18
          state_r <= H_C_WAIT_FALL;
        end
        H_C_WAIT_FALL: begin
          kick_n_r <= 1'b1;
          if (!link.done) begin
            state_r <= H_C_WAIT_RISE;
          end
        end
        H_C_WAIT_RISE: begin
          if (link.done) begin
            is_freq_r <= 1'b0;
            dig_r <= 3'(DIGITS - 1);
            state_r <= H_SCAN;
          end
        end
        H_SCAN: begin
          scan_r <= 1'b1; // RULE4
          state_r <= H_GAP;
        end
        H_GAP: begin
          scan_r <= 1'b0;
          state_r <= H_TAKE;
        end
        H_TAKE: begin
          // Digits arrive least significant first.
          shift_r <= {digit, shift_r[23:4]}; // RULE4
          if (dig_r != 3'h0) begin
            dig_r <= dig_r - 3'h1;
            state_r <= H_SCAN;
          end else if (is_freq_r) begin
            freq_r <= {digit, shift_r[23:4]};
            state_r <= H_C_KICK;
          end else begin
            level_r <= {digit, shift_r[23:4]};
            state_r <= H_IDLE;
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  assign link.count_mode_select = mode_r;
  assign link.kickoff_n = kick_n_r;
  assign link.scan_strobe = scan_r;

endmodule // seq_host

/* sim/counter_adc_sequencer_monitor.sv */
// Concurrent checks on the link between sequencer device and host.
// Assumes one clock, pclk, and an asynchronous active-low presetn.
`timescale 1ns/10ps
module counter_adc_sequencer_monitor
  import seq_pkg::*;
#(
  parameter int GATE_CYC = 1000,
  parameter int COUNT_CYC = 8
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Link signals.
  input wire logic count_mode_select,
  input wire logic kickoff_n,
  input wire logic done,
  input wire logic scan_strobe,
  input wire logic timebase_1hz,
  // Converter pins.
  input wire logic comparator,
  input wire logic integ_dir_r,
  input wire logic [2:0] step_tracking_latches
);
  int gate_r; // Cycles that done has been low in frequency mode.
  int up_r; // Cycles spent in the upward counting step.

  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Measures the frequency gate so its length can be judged.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_r <= 0;
    end else begin
      gate_r <= (!done && count_mode_select) ? gate_r + 1 : 0;
    end
  end

  // Measures the upward count so the carry moment can be judged.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_r <= 0;
    end else begin
      up_r <= (step_tracking_latches == STEP_COUNT_UP) ? up_r + 1 : 0;
    end
  end

  mode_raise_a: assert property (
    $rose(count_mode_select) |-> !timebase_1hz)
    else $error("Mode select raised while timebase high.");
  kick_follow_a: assert property (
    $rose(count_mode_select) |=> $fell(kickoff_n))
    else $error("Kickoff did not follow mode select.");
  freq_start_a: assert property (
    $fell(timebase_1hz) && count_mode_select && done |-> ##[1:3] !done)
    else $error("Frequency count did not start on timebase fall.");
  freq_end_a: assert property (
    $rose(timebase_1hz) && count_mode_select && !done |-> ##[1:3] done)
    else $error("Frequency count did not stop on timebase rise.");
  gate_len_a: assert property (
    $rose(done) && count_mode_select |->
      gate_r >= GATE_CYC - 4 && gate_r <= GATE_CYC + 4)
    else $error("Frequency gate has the wrong length.");
  mode_drop_a: assert property (
    $rose(done) && count_mode_select |-> ##[1:16] !count_mode_select)
    else $error("Mode select not dropped after the count.");
  ramp_start_a: assert property (
    $fell(kickoff_n) && !count_mode_select && done |=>
      !integ_dir_r ##1 step_tracking_latches == STEP_RAMP_UP)
    else $error("Conversion did not start ramping up.");
  count_start_a: assert property (
    $rose(comparator) && step_tracking_latches == STEP_RAMP_UP |->
      ##[1:5] (!done && step_tracking_latches == STEP_COUNT_UP))
    else $error("Counting did not start on comparator rise.");
  carry_turn_a: assert property (
    $rose(integ_dir_r) |-> ##1 (step_tracking_latches == STEP_DISCHARGE &&
      up_r >= 9997 * COUNT_CYC && up_r <= 10003 * COUNT_CYC))
    else $error("Discharge not started at the counter carry.");
  level_stop_a: assert property (
    $fell(comparator) && step_tracking_latches == STEP_DISCHARGE |->
      ##[1:5] (done && integ_dir_r && step_tracking_latches == STEP_IDLE))
    else $error("Conversion did not stop on comparator fall.");
  scan_pulse_a: assert property (
    $rose(scan_strobe) |-> done && !count_mode_select ##1 !scan_strobe)
    else $error("Scan pulse malformed or issued while busy.");

  // Main scenarios reached.
  cover property ($rose(done) && count_mode_select);
  cover property ($rose(integ_dir_r));
  cover property ($rose(scan_strobe));
endmodule // counter_adc_sequencer_monitor

/* sim/counter_adc_sequencer_tb.sv */
// Testbench joining the sequencer device and its host over the link.
// Assumes the package, link interface and both design ends are compiled.
`timescale 1ns/10ps
module counter_adc_sequencer_tb
  import seq_pkg::*;
;
  localparam int TBH = 250; // Reference ticks per timebase half.
  localparam int REF_CYC = 4; // Clock cycles per reference period.
  localparam int IF_CYC = 50; // Clock cycles per IF period.
  localparam int DIS_CYC = 800; // Discharge time before comparator falls.
  localparam int GATE = TBH * REF_CYC; // Gate length in clock cycles.
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic ref_1mhz, if_in, comparator, integ_dir_r;
  logic [2:0] step;
  int fail_count, check_count, cyc, scans, ref_cnt, if_cnt;

  seq_link_if lk ();
  sequence_controller #(.TB_HALF(TBH)) i_sequence_controller (
    .pclk(pclk), .presetn(presetn), .ref_1mhz(ref_1mhz), .if_in(if_in),
    .comparator(comparator), .integ_dir_r(integ_dir_r),
    .step_tracking_latches(step), .link(lk.dev));
  seq_host i_seq_host (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(lk.host));
  counter_adc_sequencer_monitor #(.GATE_CYC(GATE), .COUNT_CYC(2 * REF_CYC))
    i_counter_adc_sequencer_monitor (
    .pclk(pclk), .presetn(presetn),
    .count_mode_select(lk.count_mode_select), .kickoff_n(lk.kickoff_n),
    .done(lk.done), .scan_strobe(lk.scan_strobe),
    .timebase_1hz(lk.timebase_1hz), .comparator(comparator),
    .integ_dir_r(integ_dir_r), .step_tracking_latches(step));

  // Clock at 25 MHz.
  always #20 pclk = ~pclk;

  // Cycle count and scan pulse count for timing and readout checks.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (lk.scan_strobe === 1'b1) begin
      scans <= scans + 1;
    end
  end

  // Reference and IF square waves, sped up to keep the run short.
  always @(posedge pclk) begin
    ref_cnt <= (ref_cnt == REF_CYC / 2 - 1) ? 0 : ref_cnt + 1;
    if (ref_cnt == REF_CYC / 2 - 1) begin
      ref_1mhz <= ~ref_1mhz;
    end
    if_cnt <= (if_cnt == IF_CYC / 2 - 1) ? 0 : if_cnt + 1;
    if (if_cnt == IF_CYC / 2 - 1) begin
      if_in <= ~if_in;
    end
  end

  // Comparator: rises during the ramp up, falls a set time into discharge.
  initial begin
    forever begin
      @(negedge integ_dir_r);
      repeat (100) @(posedge pclk);
      comparator <= 1'b1;
      @(posedge integ_dir_r);
      repeat (DIS_CYC) @(posedge pclk);
      comparator <= 1'b0;
    end
  end

  // Counts a comparison and reports a mismatch.
  task automatic chk(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      fail_count++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One clock of a bounded wait; gives up when the limit is passed.
  task automatic tick(inout int n, input int lim);
    @(posedge pclk);
    n++;
    if (n > lim) begin
      chk(1'b0, "wait limit reached");
      final_report();
    end
  endtask

  // One APB transfer: setup, then access until pready.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do tick(n, 20); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Turns six packed BCD digits into a number.
  function automatic int bcd2int(input logic [23:0] v);
    int r;
    r = 0;
    for (int i = 5; i >= 0; i--) begin
      r = r * 10 + int'(v[4 * i +: 4]);
    end
    return r;
  endfunction

  // Idle state after reset and a refused access.
  task automatic t_reset();
    logic [31:0] rd;
    logic err;
    chk(lk.done === 1'b1 && lk.kickoff_n === 1'b1, "link idle");
    chk(lk.count_mode_select === 1'b0, "level mode at rest");
    chk(integ_dir_r === 1'b1 && step === STEP_IDLE, "idle step");
    apb(1'b0, OFS_CTRL, 32'h0, rd, err);
    chk(rd === 32'h0 && err === 1'b0, "control reset value");
    apb(1'b0, OFS_STATUS, 32'h0, rd, err);
    chk(rd[1:0] === 2'b10, "status idle and done");
    apb(1'b0, 8'h10, 32'h0, rd, err);
    chk(rd === 32'h0 && err === 1'b1, "unmapped read refused");
    $display("Test reset state finished");
  endtask

  // One frequency count, one level conversion, both read out.
  task automatic t_freq_level();
    logic [31:0] rd;
    logic err;
    int n, t0;
    apb(1'b1, OFS_CTRL, 32'h3, rd, err);
    chk(err === 1'b0, "control write");
    n = 0;
    while (lk.count_mode_select !== 1'b1) tick(n, 3 * GATE);
    chk(lk.timebase_1hz === 1'b0, "mode raised in low half");
    n = 0;
    while (lk.done !== 1'b0) tick(n, 3 * GATE);
    t0 = cyc;
    while (lk.done !== 1'b1) tick(n, 6 * GATE);
    chk(cyc - t0 inside {[GATE - 4:GATE + 4]}, "gate length");
    n = 0;
    while (lk.done !== 1'b0) tick(n, 2 * GATE);
    // The step pattern follows the state one clock later.
    @(posedge pclk);
    chk(integ_dir_r === 1'b0 && step === STEP_COUNT_UP, "count up");
    t0 = cyc;
    while (integ_dir_r !== 1'b1) tick(n, 90000);
    n = 20000 * REF_CYC;
    chk(cyc - t0 inside {[n - 24:n + 24]}, "carry after preset");
    n = 0;
    while (lk.done !== 1'b1) tick(n, 2 * DIS_CYC);
    @(posedge pclk);
    chk(step === STEP_IDLE && integ_dir_r === 1'b1, "back to idle");
    while (scans < 12) tick(n, 4000);
    repeat (3) @(posedge pclk);
    apb(1'b1, OFS_CTRL, 32'h0, rd, err);
    apb(1'b0, OFS_FREQ, 32'h0, rd, err);
    n = 20 * GATE / IF_CYC;
    chk(bcd2int(rd[23:0]) inside {[n - 20:n + 20]}, "frequency");
    apb(1'b0, OFS_LEVEL, 32'h0, rd, err);
    n = DIS_CYC / (2 * REF_CYC);
    chk(bcd2int(rd[23:0]) inside {[n - 3:n + 3]}, "level count");
    $display("Test frequency and level finished");
  endtask

  // Watchdog against a hang.
  initial begin
    repeat (100000) @(posedge pclk);
    chk(1'b0, "watchdog expired");
    final_report();
  end

  // Main sequence.
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {ref_1mhz, if_in, comparator, presetn} = 4'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_freq_level();
    final_report();
  end
endmodule // counter_adc_sequencer_tb
